// file: core/mstm_monitor.v
// Motor status monitor: classification, counters and time totals
`timescale 1ns/1ps
// Functional notes
// R1 - Stopped after current under no-load over 10 ms
// R2 - Above start detect from stopped means starting
// R3 - Start holds while under locked rotor limit; the code holds start while at or above max overload instead
// R4 - Under max overload ends start, running
// R5 - Load normal between no-load and scaled nominal
// R6 - Overloading above nominal, not above max overload
// R7 - Above max overload means stalled
// R8 - Under no-load from running means stopped again
// R9 - Missing phase: one phase lost while starting/running
// R10 - Count starts, successful starts and stops
// R11 - Accumulate running time and starting time
// R12 - Total stopped time and last stop time
// R13 - Shared motor data copies follow any edit
// R14 - Status outputs usable, optional change events
// R15 - User logic blocks overcurrent with start and-not high
// R16 - High overcurrent may drive relay directly
// R17 - Released stage needs start detect below pick-up
// R18 - Direct/star-delta start only if rise within 10 ms
// R19 - Evaluate once per measurement cycle, synchronously
`include "mstm_defines.vh"

module mstm_monitor #(
   parameter STOP_DELAY_CYC = `MSTM_STOP_DELAY_CYC,
   parameter START_WIN_CYC  = `MSTM_START_WIN_CYC,
   parameter TICK_CYC       = `MSTM_TICK_CYC
) (
   input  wire                        core_clk,
   input  wire                        reset,
   input  wire                        meas_valid,
   input  wire [`MSTM_CUR_W-1:0]      phase_a_cur,
   input  wire [`MSTM_CUR_W-1:0]      phase_b_cur,
   input  wire [`MSTM_CUR_W-1:0]      phase_c_cur,
   input  wire                        setting_load,
   input  wire [1:0]                  start_mode,
   input  wire [`MSTM_CUR_W-1:0]      no_load_cur,
   input  wire [`MSTM_CUR_W-1:0]      start_detect_cur,
   input  wire [`MSTM_CUR_W-1:0]      locked_rotor_cur,
   input  wire [`MSTM_CUR_W-1:0]      max_overload_cur,
   input  wire [`MSTM_CUR_W-1:0]      nominal_cur,
   input  wire [`MSTM_FAC_W-1:0]      service_factor,
   input  wire [`MSTM_FAC_W-1:0]      ambient_factor,
   input  wire [`MSTM_ST_W-1:0]       event_enable,
   input  wire [`MSTM_CNT_W-1:0]      time_now_ms,
   output reg                         motor_stopped,
   output reg                         motor_starting_flag,
   output reg                         motor_running,
   output reg                         motor_stalled,
   output reg                         missing_phase,
   output reg                         load_normal,
   output reg                         overloading,
   output reg                         high_overcurrent_flag,
   output reg  [`MSTM_ST_W-1:0]       status_event,
   output reg  [`MSTM_CNT_W-1:0]      start_count,
   output reg  [`MSTM_CNT_W-1:0]      good_start_count,
   output reg  [`MSTM_CNT_W-1:0]      stop_count,
   output reg  [`MSTM_CNT_W-1:0]      run_time_ms,
   output reg  [`MSTM_CNT_W-1:0]      start_time_ms,
   output reg  [`MSTM_CNT_W-1:0]      stop_time_ms,
   output reg  [`MSTM_CNT_W-1:0]      last_stop_ms
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_STOP  = 2'h1;
   localparam [1:0] ST_START = 2'h2;
   localparam [1:0] ST_RUN   = 2'h3;

   localparam [`MSTM_TMR_W-1:0] STOP_LIM = STOP_DELAY_CYC[`MSTM_TMR_W-1:0];
   localparam [`MSTM_TMR_W-1:0] WIN_LIM  = START_WIN_CYC[`MSTM_TMR_W-1:0];
   localparam [`MSTM_TMR_W-1:0] TICK_LIM = TICK_CYC[`MSTM_TMR_W-1:0];

   // ----------------------------------------
   // Motor data copy
   // ----------------------------------------
   // Any function editing motor data pulses setting_load, so this copy follows
   reg [1:0]             mode_reg;
   reg [`MSTM_CUR_W-1:0] nl_reg;
   reg [`MSTM_CUR_W-1:0] sd_reg;
   reg [`MSTM_CUR_W-1:0] lr_reg;
   reg [`MSTM_CUR_W-1:0] mo_reg;
   reg [`MSTM_CUR_W-1:0] nom_reg;

   wire [2*`MSTM_CUR_W-1:0] nom_prod;
   assign nom_prod = nominal_cur * service_factor * ambient_factor;

   always @(posedge core_clk) begin
      if (reset) begin
         mode_reg <= `MSTM_MODE_DIRECT;
         nl_reg   <= {`MSTM_CUR_W{1'b0}};
         sd_reg   <= {`MSTM_CUR_W{1'b1}};
         lr_reg   <= {`MSTM_CUR_W{1'b1}};
         mo_reg   <= {`MSTM_CUR_W{1'b1}};
         nom_reg  <= {`MSTM_CUR_W{1'b1}};
      end else if (setting_load) begin                                      // [R13]
         mode_reg <= start_mode;
         nl_reg   <= no_load_cur;
         sd_reg   <= start_detect_cur;
         lr_reg   <= locked_rotor_cur;
         mo_reg   <= max_overload_cur;
         // Saturate rather than wrap when factors push past full scale
         if (|nom_prod[2*`MSTM_CUR_W-1:`MSTM_FAC_SHIFT+`MSTM_CUR_W])
            nom_reg <= {`MSTM_CUR_W{1'b1}};
         else
            nom_reg <= nom_prod[`MSTM_FAC_SHIFT+`MSTM_CUR_W-1:`MSTM_FAC_SHIFT]; // [R5]
      end
   end

   // ----------------------------------------
   // Current classification
   // ----------------------------------------
   reg [`MSTM_CUR_W-1:0] max_ab;
   reg [`MSTM_CUR_W-1:0] i_max;
   reg                   below_nl;
   reg                   phase_lost;

   always @* begin
      max_ab     = (phase_a_cur > phase_b_cur) ? phase_a_cur : phase_b_cur;
      i_max      = (max_ab > phase_c_cur) ? max_ab : phase_c_cur;
      below_nl   = (i_max < nl_reg);
      phase_lost = !below_nl && ((phase_a_cur < nl_reg) || (phase_b_cur < nl_reg)
                   || (phase_c_cur < nl_reg));                             // [R9]
   end

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   reg [1:0]              state_reg;
   reg [1:0]              state_next;
   reg [`MSTM_TMR_W-1:0]  low_cnt_reg;
   reg [`MSTM_TMR_W-1:0]  win_cnt_reg;
   reg                    win_act_reg;
   reg [`MSTM_TMR_W-1:0]  tick_cnt_reg;
   reg                    below_reg;
   wire                   low_done;
   wire                   win_open;
   wire                   ms_tick;

   assign low_done = (low_cnt_reg >= STOP_LIM);
   assign win_open = win_act_reg && (win_cnt_reg < WIN_LIM);
   assign ms_tick  = (tick_cnt_reg == TICK_LIM - 1'b1);

   always @(posedge core_clk) begin
      if (reset) begin
         below_reg    <= 1'b0;
         low_cnt_reg  <= {`MSTM_TMR_W{1'b0}};
         win_act_reg  <= 1'b0;
         win_cnt_reg  <= {`MSTM_TMR_W{1'b0}};
         tick_cnt_reg <= {`MSTM_TMR_W{1'b0}};
      end else begin
         tick_cnt_reg <= ms_tick ? {`MSTM_TMR_W{1'b0}} : tick_cnt_reg + 1'b1;
         if (meas_valid)
            below_reg <= below_nl;
         // Continuous time under no-load, measured in clocks between samples
         if (meas_valid && !below_nl)
            low_cnt_reg <= {`MSTM_TMR_W{1'b0}};
         else if ((below_reg || (meas_valid && below_nl)) && !low_done)
            low_cnt_reg <= low_cnt_reg + 1'b1;                              // [R1]
         // Rise window opens on first sample above no-load while stopped
         if (state_reg != ST_STOP || (meas_valid && below_nl)) begin
            win_act_reg <= 1'b0;
            win_cnt_reg <= {`MSTM_TMR_W{1'b0}};
         end else if (meas_valid && !win_act_reg) begin
            win_act_reg <= 1'b1;
            win_cnt_reg <= {`MSTM_TMR_W{1'b0}};
         end else if (win_act_reg && win_open) begin
            win_cnt_reg <= win_cnt_reg + 1'b1;                              // [R18]
         end
      end
   end

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   reg start_evt;
   reg good_start_evt;
   reg stop_evt;
   reg rise_ok;

   always @* begin
      state_next     = state_reg;
      start_evt      = 1'b0;
      good_start_evt = 1'b0;
      stop_evt       = 1'b0;
      // Soft start has no rise-time demand
      rise_ok = (mode_reg == `MSTM_MODE_SOFT) || !win_act_reg || win_open; // [R18]
      if (meas_valid) begin                                                 // [R19]
         case (state_reg)
            ST_IDLE: begin
               if (below_nl && low_done)
                  state_next = ST_STOP;
               else if (!below_nl)
                  state_next = ST_RUN;
            end
            ST_STOP: begin
               if (!below_nl && i_max > sd_reg && rise_ok) begin            // [R2]
                  state_next = ST_START;
                  start_evt  = 1'b1;                                        // [R10]
               end else if (!below_nl && !rise_ok) begin
                  // Slow rise: motor carries current but no start is counted
                  state_next = ST_RUN;                                      // [R18]
               end
            end
            ST_START: begin
               if (below_nl && low_done) begin
                  state_next = ST_STOP;
                  stop_evt   = 1'b1;
               end else if (!below_nl && i_max < mo_reg) begin             // [R4]
                  state_next     = ST_RUN;
                  good_start_evt = 1'b1;                                    // [R10]
               end
            end
            ST_RUN: begin
               if (below_nl && low_done) begin                              // [R8]
                  state_next = ST_STOP;
                  stop_evt   = 1'b1;                                        // [R10]
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always @(posedge core_clk) begin
      if (reset)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   reg [`MSTM_ST_W-1:0] status_next;
   wire [`MSTM_ST_W-1:0] status_now;

   assign status_now = {high_overcurrent_flag, overloading, load_normal, missing_phase,
                        motor_stalled, motor_running, motor_starting_flag, motor_stopped};

   always @* begin
      status_next = status_now;
      if (meas_valid) begin
         status_next[`MSTM_ST_STOPPED]     = (state_next == ST_STOP);       // [R1]
         // Start holds while at or above max overload; beyond it the motor is stalled
         status_next[`MSTM_ST_STARTING]    = (state_next == ST_START);      // [R3]
         status_next[`MSTM_ST_RUNNING]     = (state_next == ST_RUN);        // [R4]
         status_next[`MSTM_ST_STALLED]     = (state_next == ST_RUN || state_next == ST_START)
                                             && (i_max > mo_reg);           // [R7]
         status_next[`MSTM_ST_MISS_PHASE]  = (state_next == ST_RUN || state_next == ST_START)
                                             && phase_lost;                 // [R9]
         status_next[`MSTM_ST_LOAD_NORMAL] = (state_next == ST_RUN) && !below_nl
                                             && (i_max <= nom_reg);         // [R5]
         status_next[`MSTM_ST_OVERLOAD]    = (state_next == ST_RUN) && (i_max > nom_reg)
                                             && (i_max <= mo_reg);          // [R6]
         status_next[`MSTM_ST_HIGH_OC]     = (state_next != ST_STOP) && (i_max >= lr_reg);
      end
   end

   always @(posedge core_clk) begin
      if (reset) begin
         {high_overcurrent_flag, overloading, load_normal, missing_phase,
          motor_stalled, motor_running, motor_starting_flag, motor_stopped} <= {`MSTM_ST_W{1'b0}};
         status_event <= {`MSTM_ST_W{1'b0}};
      end else begin
         {high_overcurrent_flag, overloading, load_normal, missing_phase,
          motor_stalled, motor_running, motor_starting_flag, motor_stopped} <= status_next;
         status_event <= (status_next ^ status_now) & event_enable;         // [R14]
      end
   end

   // ----------------------------------------
   // Counters and time totals
   // ----------------------------------------
   // Totals wrap silently; at 1 ms per count that is about 49 days
   always @(posedge core_clk) begin
      if (reset) begin
         start_count      <= {`MSTM_CNT_W{1'b0}};
         good_start_count <= {`MSTM_CNT_W{1'b0}};
         stop_count       <= {`MSTM_CNT_W{1'b0}};
         run_time_ms      <= {`MSTM_CNT_W{1'b0}};
         start_time_ms    <= {`MSTM_CNT_W{1'b0}};
         stop_time_ms     <= {`MSTM_CNT_W{1'b0}};
         last_stop_ms     <= {`MSTM_CNT_W{1'b0}};
      end else begin
         if (start_evt)
            start_count <= start_count + 1'b1;                              // [R10]
         if (good_start_evt)
            good_start_count <= good_start_count + 1'b1;                    // [R10]
         if (stop_evt) begin
            stop_count   <= stop_count + 1'b1;                              // [R10]
            last_stop_ms <= time_now_ms;                                    // [R12]
         end
         if (ms_tick && state_reg == ST_RUN)
            run_time_ms <= run_time_ms + 1'b1;                              // [R11]
         if (ms_tick && state_reg == ST_START)
            start_time_ms <= start_time_ms + 1'b1;                          // [R11]
         if (ms_tick && state_reg == ST_STOP)
            stop_time_ms <= stop_time_ms + 1'b1;                            // [R12]
      end
   end

endmodule

// file: shared/mstm_defines.vh
// Constants for the motor status monitor
`ifndef MSTM_DEFINES_VH
`define MSTM_DEFINES_VH

// ----------------------------------------
// Widths and scaling
// ----------------------------------------
`define MSTM_CUR_W          16
`define MSTM_FAC_W          8
`define MSTM_FAC_SHIFT      14
`define MSTM_CNT_W          32
`define MSTM_TMR_W          24

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSTM_CLK_KHZ        25000
`define MSTM_STOP_DELAY_MS  10
`define MSTM_START_WIN_MS   10
`define MSTM_TICK_MS        1
`define MSTM_STOP_DELAY_CYC (`MSTM_CLK_KHZ * `MSTM_STOP_DELAY_MS + 1)
`define MSTM_START_WIN_CYC  (`MSTM_CLK_KHZ * `MSTM_START_WIN_MS)
`define MSTM_TICK_CYC       (`MSTM_CLK_KHZ * `MSTM_TICK_MS)

// ----------------------------------------
// Start mode codes
// ----------------------------------------
`define MSTM_MODE_DIRECT    2'h0
`define MSTM_MODE_STAR_DELTA 2'h1
`define MSTM_MODE_SOFT      2'h2

// ----------------------------------------
// Status vector bit positions
// ----------------------------------------
`define MSTM_ST_STOPPED     0
`define MSTM_ST_STARTING    1
`define MSTM_ST_RUNNING     2
`define MSTM_ST_STALLED     3
`define MSTM_ST_MISS_PHASE  4
`define MSTM_ST_LOAD_NORMAL 5
`define MSTM_ST_OVERLOAD    6
`define MSTM_ST_HIGH_OC     7
`define MSTM_ST_W           8

`endif

// file: test/mstm_meas_src.sv
// Current measurement source feeding phase samples
`timescale 1ns/1ps
module mstm_meas_src (
   input  wire        core_clk,
   input  wire        motor_starting_flag,
   input  wire        high_overcurrent_flag,
   output reg         meas_valid,
   output reg  [15:0] phase_a_cur,
   output reg  [15:0] phase_b_cur,
   output reg  [15:0] phase_c_cur,
   output reg         overcurrent_stage_pickup,
   output wire        user_logic_output_one,
   output wire        user_logic_output_two,
   output wire        relay_trip
);
   // Pick-up of the first overcurrent stage, kept above start detect
   localparam [15:0] OC_PICKUP = 16'h0200;
   // User logic: block the stage while starting unless high overcurrent
   assign user_logic_output_one = motor_starting_flag & ~high_overcurrent_flag;
   assign user_logic_output_two = high_overcurrent_flag & overcurrent_stage_pickup;
   assign relay_trip            = high_overcurrent_flag;
   initial begin
      overcurrent_stage_pickup = 1'b0;
      meas_valid = 1'b0;
      phase_a_cur = 16'h0000;
      phase_b_cur = 16'h0000;
      phase_c_cur = 16'h0000;
   end
   // Three phases go as one sample; outside it the lines carry junk
   task sample(input [15:0] a, input [15:0] b, input [15:0] c);
      begin
         @(posedge core_clk);
         meas_valid <= 1'b1;
         phase_a_cur <= a;
         phase_b_cur <= b;
         phase_c_cur <= c;
         overcurrent_stage_pickup <= (a > OC_PICKUP) || (b > OC_PICKUP) || (c > OC_PICKUP);
         @(posedge core_clk);
         meas_valid <= 1'b0;
         phase_a_cur <= ~a;
         phase_b_cur <= ~b;
         phase_c_cur <= ~c;
      end
   endtask
endmodule

// file: test/mstm_monitor_checker.sv
// Temporal checks on the motor status monitor ports
`timescale 1ns/1ps
`include "mstm_defines.vh"
module mstm_monitor_checker (
   input wire                   core_clk,
   input wire                   reset,
   input wire                   meas_valid,
   input wire [`MSTM_ST_W-1:0]  event_enable,
   input wire [`MSTM_CNT_W-1:0] time_now_ms,
   input wire                   motor_stopped,
   input wire                   motor_starting_flag,
   input wire                   motor_running,
   input wire                   motor_stalled,
   input wire                   missing_phase,
   input wire                   load_normal,
   input wire                   overloading,
   input wire                   high_overcurrent_flag,
   input wire [`MSTM_ST_W-1:0]  status_event,
   input wire [`MSTM_CNT_W-1:0] start_count,
   input wire [`MSTM_CNT_W-1:0] good_start_count,
   input wire [`MSTM_CNT_W-1:0] stop_count,
   input wire [`MSTM_CNT_W-1:0] last_stop_ms
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   wire active = motor_running | motor_starting_flag;
   sequence s_start;
      $rose(motor_starting_flag);
   endsequence
   sequence s_stop;
      $rose(motor_stopped) && ($past(motor_running) || $past(motor_starting_flag));
   endsequence
   property p_evt_cause;
      (status_event != 8'h00) |-> $past(meas_valid);
   endproperty
   a_evt_cause: assert property (p_evt_cause) else $error("event without sample");
   property p_evt_mask;
      (status_event & ~$past(event_enable)) == 8'h00;
   endproperty
   a_evt_mask: assert property (p_evt_mask) else $error("masked event seen");
   property p_hold;
      !meas_valid |=> $stable({motor_stopped, active, stop_count, start_count});
   endproperty
   a_hold: assert property (p_hold) else $error("status moved without sample");
   property p_start;
      s_start |-> $past(motor_stopped) && start_count == $past(start_count) + 32'h1;
   endproperty
   a_start: assert property (p_start) else $error("start not counted");
   property p_good;
      $rose(motor_running) && $past(motor_starting_flag) |-> good_start_count == $past(good_start_count) + 32'h1;
   endproperty
   a_good: assert property (p_good) else $error("good start not counted");
   property p_stop;
      s_stop |-> stop_count == $past(stop_count) + 32'h1 && last_stop_ms == $past(time_now_ms);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not recorded");
   property p_stall;
      motor_stalled |-> active && !overloading && !motor_stopped;
   endproperty
   a_stall: assert property (p_stall) else $error("stall outside run");
   property p_miss;
      missing_phase |-> active;
   endproperty
   a_miss: assert property (p_miss) else $error("missing phase outside run");
   property p_stopped;
      motor_stopped |-> !active && !high_overcurrent_flag && !load_normal;
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped with run flags");
endmodule

// file: test/motor_status_monitor_tb.sv
// Self-checking bench for the motor status monitor
`timescale 1ns/1ps
`include "mstm_defines.vh"
`define CHK(nm, ex, got) begin \
   compares = compares + 1; \
   if ((got) !== (ex)) begin \
      errors = errors + 1; \
      $display("[FAIL] %s exp %h got %h", nm, ex, got); \
   end \
end
module motor_status_monitor_tb;
   reg         core_clk = 1'b0, reset = 1'b1, setting_load = 1'b0;
   reg  [1:0]  start_mode = 2'h0;
   reg  [15:0] nominal_cur = 16'h0200;
   // Start detect kept under the overcurrent stage pick-up
   reg  [15:0] nl_cur = 16'h0010, sd_cur = 16'h0100, lr_cur = 16'h0800, mo_cur = 16'h0400;
   wire        ocpk, ulo1, ulo2, relay;
   reg  [7:0]  service_factor = 8'h80, ambient_factor = 8'h80, event_enable = 8'hfe, ev;
   reg  [31:0] time_now_ms = 32'h0;
   wire        meas_valid, mstp, mstr, mrun, mstl, mph, lnorm, ovl, hoc;
   wire [15:0] pa, pb, pc;
   wire [7:0]  status_event;
   wire [31:0] sc, gc, pc_stop, rt, stt, spt, lst;
   wire [7:0]  st = {hoc, ovl, lnorm, mph, mstl, mrun, mstr, mstp};
   integer     errors = 0, compares = 0, cycles = 0;
   always #20 core_clk = ~core_clk;
   mstm_meas_src i_src (.core_clk(core_clk), .motor_starting_flag(mstr), .high_overcurrent_flag(hoc),
      .meas_valid(meas_valid), .phase_a_cur(pa), .phase_b_cur(pb), .phase_c_cur(pc),
      .overcurrent_stage_pickup(ocpk), .user_logic_output_one(ulo1), .user_logic_output_two(ulo2),
      .relay_trip(relay));
   // Short counts keep the run small
   mstm_monitor #(.STOP_DELAY_CYC(20), .START_WIN_CYC(16), .TICK_CYC(10)) i_dut (
      .core_clk(core_clk), .reset(reset), .meas_valid(meas_valid), .phase_a_cur(pa), .phase_b_cur(pb),
      .phase_c_cur(pc), .setting_load(setting_load), .start_mode(start_mode), .no_load_cur(nl_cur),
      .start_detect_cur(sd_cur), .locked_rotor_cur(lr_cur), .max_overload_cur(mo_cur),
      .nominal_cur(nominal_cur), .service_factor(service_factor), .ambient_factor(ambient_factor),
      .event_enable(event_enable), .time_now_ms(time_now_ms), .motor_stopped(mstp),
      .motor_starting_flag(mstr), .motor_running(mrun), .motor_stalled(mstl), .missing_phase(mph),
      .load_normal(lnorm), .overloading(ovl), .high_overcurrent_flag(hoc), .status_event(status_event),
      .start_count(sc), .good_start_count(gc), .stop_count(pc_stop), .run_time_ms(rt),
      .start_time_ms(stt), .stop_time_ms(spt), .last_stop_ms(lst));
   task conclude;
      begin
         if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         conclude;
      end
   end
   task load(input [1:0] m, input [15:0] nom, input [7:0] sf);
      begin
         @(posedge core_clk);
         start_mode <= m;
         nominal_cur <= nom;
         service_factor <= sf;
         setting_load <= 1'b1;
         @(posedge core_clk);
         setting_load <= 1'b0;
      end
   endtask
   task meas(input [15:0] a, input [15:0] b, input [15:0] c, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            i_src.sample(a, b, c);
            #1;
            ev = status_event;
            repeat (2) @(posedge core_clk);
         end
      end
   endtask
   // ----------------------------------------
   // Scenario sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      load(`MSTM_MODE_DIRECT, 16'h0200, 8'h80);
      meas(16'h0005, 16'h0005, 16'h0005, 8);
      `CHK("stopped", 8'h01, st)
      meas(16'h0300, 16'h0300, 16'h0300, 1);
      `CHK("starting", 8'h02, st)
      `CHK("start event", 8'h02, ev)
      `CHK("starts", 32'h1, sc)
      meas(16'h0600, 16'h0600, 16'h0600, 1);
      `CHK("start held", 8'h0a, st)
      `CHK("oc blocked", 1'b1, ulo1)
      meas(16'h0100, 16'h0100, 16'h0100, 1);
      `CHK("running", 8'h24, st)
      `CHK("good starts", 32'h1, gc)
      meas(16'h0300, 16'h0300, 16'h0300, 1);
      `CHK("overload", 8'h44, st)
      meas(16'h0500, 16'h0500, 16'h0500, 1);
      `CHK("stalled", 8'h0c, st)
      meas(16'h0100, 16'h0100, 16'h0005, 1);
      `CHK("phase lost", 8'h34, st)
      meas(16'h0900, 16'h0900, 16'h0900, 1);
      `CHK("high current", 8'h8c, st)
      `CHK("relay", 1'b1, relay)
      time_now_ms <= 32'h0000_1234;
      meas(16'h0005, 16'h0005, 16'h0005, 8);
      `CHK("stopped again", 8'h01, st)
      `CHK("stops", 32'h1, pc_stop)
      `CHK("last stop", 32'h0000_1234, lst)
      `CHK("run time", 1'b1, rt > 32'h0)
      `CHK("start time", 1'b1, stt > 32'h0)
      // Slow rise in star-delta is no start
      load(`MSTM_MODE_STAR_DELTA, 16'h0200, 8'h80);
      meas(16'h0050, 16'h0050, 16'h0050, 6);
      meas(16'h0300, 16'h0300, 16'h0300, 1);
      `CHK("slow rise", 8'h44, st)
      `CHK("starts kept", 32'h1, sc)
      sd_cur <= 16'h0180;
      load(`MSTM_MODE_SOFT, 16'h0200, 8'h80);
      meas(16'h0005, 16'h0005, 16'h0005, 8);
      meas(16'h0050, 16'h0050, 16'h0050, 6);
      meas(16'h0140, 16'h0140, 16'h0140, 1);
      `CHK("detect raised", 8'h01, st)
      meas(16'h0300, 16'h0300, 16'h0300, 1);
      `CHK("soft start", 8'h02, st)
      `CHK("soft starts", 32'h2, sc)
      meas(16'h0900, 16'h0900, 16'h0900, 1);
      `CHK("start high oc", 8'h8a, st)
      `CHK("block released", 1'b0, ulo1)
      `CHK("fast setting", 1'b1, ulo2)
      load(`MSTM_MODE_SOFT, 16'h0080, 8'h80);
      meas(16'h0100, 16'h0100, 16'h0100, 1);
      `CHK("new nominal", 8'h44, st)
      ambient_factor <= 8'hc0;
      event_enable <= 8'hff;
      load(`MSTM_MODE_SOFT, 16'h0080, 8'ha0);
      meas(16'h00e0, 16'h00e0, 16'h00e0, 1);
      `CHK("scaled nominal", 1'b1, lnorm)
      nl_cur <= 16'h0100;
      load(`MSTM_MODE_SOFT, 16'h0080, 8'ha0);
      meas(16'h00e0, 16'h00e0, 16'h00e0, 1);
      `CHK("no-load moved", 8'h04, st)
      `CHK("stop time", 1'b1, spt > 32'h0)
      conclude;
   end
endmodule
bind mstm_monitor mstm_monitor_checker i_chk (.core_clk(core_clk), .reset(reset), .meas_valid(meas_valid),
   .event_enable(event_enable), .time_now_ms(time_now_ms), .motor_stopped(motor_stopped),
   .motor_starting_flag(motor_starting_flag), .motor_running(motor_running), .motor_stalled(motor_stalled),
   .missing_phase(missing_phase), .load_normal(load_normal), .overloading(overloading),
   .high_overcurrent_flag(high_overcurrent_flag), .status_event(status_event), .start_count(start_count),
   .good_start_count(good_start_count), .stop_count(stop_count), .last_stop_ms(last_stop_ms));
